// ==== src/osdc_cmd.sv ====
// serial command interpreter and display control registers of the osd controller
//
// Summary of operation
// [R1] vertical start offset is six bits, one count is two line periods
// [R2] vertical offset unit is the horizontal sync period
// [R3] first byte 1011 is horizontal size/position; low nibble two size fields
// [R4] size field 00/11 one clock per dot, 01 two, 10 three
// [R5] horizontal start is six bits, delay twice field value in clocks
// [R6] horizontal units are oscillator periods of the current mode
// [R7] bit 7 low marks a data byte; host sends data with it low
// [R8] first byte 1100 is primary control: test, erase, osc stop, reset
// [R9] host always writes test bit as zero
// [R10] erase bit fills every display memory word with 7f, about 500 us
// [R11] host erases memory only while display is off
// [R12] osc stop halts oscillators only in external sync with display off
// [R13] soft reset clears registers, display off, held while select stays low
// [R14] fill bit zero covers character area, one the whole video area
// [R15] blink period bit zero about half second, one about one second
// [R16] blink with reverse alternates normal and reverse instead of blanking
// [R17] first byte 1101 selects standard, lines, scan type and sync source
// [R18] half level or colour off gives background level without chroma
// [R19] burst bit zero emits colour burst, one suppresses it
// [R20] hue field maps to eight hues, six usable with the slow clock
// [R21] first byte 1110 is sync detect; select zero routes separator out
// [R22] hardware reset clears every command field
// [R23] last command id kept until next first byte; select high returns to address mode; after 1001 the code ignores further first bytes until select high
// [R24] display enable one shows characters, zero suppresses them
// [R25] first size field is first line, second field second line
`timescale 1ns/10ps
`include "osdc_map.svh"
module osdc_cmd import osdc_pkg::*; #(
  parameter int ERASE_CYC = `OSDC_ERASE_CYC,
  parameter int BLINK_FAST_CYC = `OSDC_BLINK_FAST_CYC,
  parameter int BLINK_SLOW_CYC = `OSDC_BLINK_SLOW_CYC,
  parameter int VRAM_DEPTH = `OSDC_VRAM_DEPTH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clkEn,
  // serial command pins
  input wire logic serialChipSelect_n,
  input wire logic serialClk,
  input wire logic serialData,
  // video timing inputs
  input wire logic hsyncPulse,
  input wire logic dotClkTick,
  input wire logic charPixel,
  input wire logic lineSel,
  input wire logic sepSignal,
  input wire logic [6:0] vramRdAddr,
  // configuration outputs
  output osdc_horiz_t horizCfg,
  output osdc_disp_t dispCfg,
  output osdc_video_t videoCfg,
  output logic [5:0] verticalStartOffset,
  output logic separatorOutputSelect,
  output logic factoryTestSelect,
  // derived outputs
  output logic oscillatorHalt,
  output logic eraseBusy,
  output logic pixelOut,
  output logic chromaEnable,
  output logic burstEnable,
  output logic hStartDone,
  output logic vStartDone,
  output logic separatorOut,
  output logic [6:0] vramRdData
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] csSync_q, sclkSync_q, sdSync_q;
  logic sclkPrev_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      csSync_q <= 2'h3;
      sclkSync_q <= 2'h3;
      sdSync_q <= 2'h0;
      sclkPrev_q <= 1'h1;
    end else if (clkEn) begin
      csSync_q <= {csSync_q[0], serialChipSelect_n};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      sdSync_q <= {sdSync_q[0], serialData};
      sclkPrev_q <= sclkSync_q[1];
    end
  end
  wire csLow = !csSync_q[1];
  wire sclkRise = sclkSync_q[1] && !sclkPrev_q;

  // ****************************************
  // byte assembly, lsb first
  // ****************************************
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic byteValid_q;
  logic [7:0] byte_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 8'h00;
      bitCnt_q <= 3'h0;
      byteValid_q <= 1'h0;
      byte_q <= 8'h00;
    end else if (clkEn) begin
      byteValid_q <= 1'h0;
      if (!csLow) begin
        bitCnt_q <= 3'h0;
      end else if (sclkRise) begin
        shift_q <= {sdSync_q[1], shift_q[7:1]};
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == 3'h7) begin
          byteValid_q <= 1'h1;
          byte_q <= {sdSync_q[1], shift_q[7:1]};
        end
      end
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  logic [3:0] opcode_q;
  logic charLock_q;
  logic softReset_q;
  wire isFirst = byteValid_q && byte_q[7]; // [R7]
  wire isData = byteValid_q && !byte_q[7]; // [R7]
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_q <= `OSDC_OP_ADDR;
      charLock_q <= 1'h0;
    end else if (clkEn) begin
      if (!csLow) begin
        opcode_q <= `OSDC_OP_ADDR; // [R23]
        charLock_q <= 1'h0;
      end else if (isFirst && !charLock_q) begin
        opcode_q <= byte_q[7:4]; // [R23]
        charLock_q <= (byte_q[7:4] == `OSDC_OP_CHAR);
      end
    end
  end
  wire firstOp = isFirst && !charLock_q;

  // soft reset stays in force until the select pin rises
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      softReset_q <= 1'h0;
    end else if (clkEn) begin
      if (!csLow) softReset_q <= 1'h0; // [R13]
      else if (firstOp && byte_q[7:4] == `OSDC_OP_PRIM && byte_q[0]) softReset_q <= 1'h1; // [R13]
    end
  end

  // ****************************************
  // command registers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      horizCfg <= '0; // [R22]
      dispCfg <= '0;
      videoCfg <= '0;
      verticalStartOffset <= 6'h00;
      separatorOutputSelect <= 1'h0;
      factoryTestSelect <= 1'h0;
    end else if (clkEn) begin
      if (softReset_q) begin
        horizCfg <= '0; // [R13]
        dispCfg <= '0;
        videoCfg <= '0;
        verticalStartOffset <= 6'h00;
        separatorOutputSelect <= 1'h0;
        factoryTestSelect <= 1'h0;
      end else if (firstOp) begin
        case (byte_q[7:4])
          `OSDC_OP_HORIZ: horizCfg[9:6] <= byte_q[3:0]; // [R3] [R25]
          `OSDC_OP_PRIM: factoryTestSelect <= byte_q[3]; // [R8] [R9]
          `OSDC_OP_VIDEO: videoCfg[9:6] <= byte_q[3:0]; // [R17]
          `OSDC_OP_SYNC: separatorOutputSelect <= byte_q[3]; // [R21]
          default: ;
        endcase
      end else if (isData) begin
        case (opcode_q)
          `OSDC_OP_VERT: verticalStartOffset <= byte_q[5:0]; // [R1]
          `OSDC_OP_HORIZ: horizCfg.horizontalStartOffset <= byte_q[5:0]; // [R5]
          `OSDC_OP_PRIM: dispCfg <= byte_q[6:0]; // [R14] [R15] [R24]
          `OSDC_OP_VIDEO: videoCfg[5:0] <= byte_q[5:0]; // [R18] [R19] [R20]
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // display memory erase
  // ****************************************
  logic [6:0] vram [VRAM_DEPTH];
  logic [$clog2(VRAM_DEPTH)-1:0] eraseAddr_q;
  // one word per step spreads the fill over the required erase time
  localparam int STEP = (ERASE_CYC / VRAM_DEPTH) < 1 ? 1 : ERASE_CYC / VRAM_DEPTH;
  logic [$clog2(STEP+1)-1:0] stepCnt_q;
  wire eraseReq = firstOp && byte_q[7:4] == `OSDC_OP_PRIM && byte_q[2];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eraseBusy <= 1'h0;
      eraseAddr_q <= '0;
      stepCnt_q <= '0;
    end else if (clkEn) begin
      if (eraseReq && !eraseBusy) begin
        eraseBusy <= 1'h1; // [R10]
        eraseAddr_q <= '0;
        stepCnt_q <= '0;
      end else if (eraseBusy) begin
        if (stepCnt_q == ($clog2(STEP+1))'(STEP - 1)) begin
          stepCnt_q <= '0;
          if (eraseAddr_q == ($clog2(VRAM_DEPTH))'(VRAM_DEPTH - 1)) eraseBusy <= 1'h0;
          else eraseAddr_q <= eraseAddr_q + ($clog2(VRAM_DEPTH))'(1);
        end else begin
          stepCnt_q <= stepCnt_q + ($clog2(STEP+1))'(1);
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (clkEn && eraseBusy) vram[eraseAddr_q] <= `OSDC_ERASE_CODE; // [R10]
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) vramRdData <= 7'h00;
    else if (clkEn) vramRdData <= vram[vramRdAddr];
  end

  // ****************************************
  // oscillator halt
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oscillatorHalt <= 1'h0;
    end else if (clkEn) begin
      if (softReset_q) oscillatorHalt <= 1'h0;
      else if (firstOp && byte_q[7:4] == `OSDC_OP_PRIM)
        oscillatorHalt <= byte_q[1] && !videoCfg.internalSync &&
          !dispCfg.characterDisplayEnable; // [R12]
      else if (videoCfg.internalSync || dispCfg.characterDisplayEnable)
        oscillatorHalt <= 1'h0; // [R12]
    end
  end

  // ****************************************
  // blink timer
  // ****************************************
  logic [$clog2(BLINK_SLOW_CYC)-1:0] blinkCnt_q;
  logic blinkPhase_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt_q <= '0;
      blinkPhase_q <= 1'h0;
    end else if (clkEn) begin
      if (blinkCnt_q >= ($clog2(BLINK_SLOW_CYC))'((dispCfg.blinkPeriodSelect ?
          BLINK_SLOW_CYC : BLINK_FAST_CYC) - 1)) begin // [R15]
        blinkCnt_q <= '0;
        blinkPhase_q <= !blinkPhase_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + ($clog2(BLINK_SLOW_CYC))'(1);
      end
    end
  end

  // ****************************************
  // start position counters and pixel path
  // ****************************************
  logic [1:0] hsSync_q;
  logic hsPrev_q;
  logic [6:0] hCnt_q;
  logic [7:0] vCnt_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hsSync_q <= 2'h0;
      hsPrev_q <= 1'h0;
      hCnt_q <= 7'h00;
      vCnt_q <= 8'h00;
      hStartDone <= 1'h0;
      vStartDone <= 1'h0;
    end else if (clkEn) begin
      hsSync_q <= {hsSync_q[0], hsyncPulse};
      hsPrev_q <= hsSync_q[1];
      if (hsSync_q[1] && !hsPrev_q) begin
        hCnt_q <= 7'h00;
        hStartDone <= 1'h0;
        if (!vStartDone) vCnt_q <= vCnt_q + 8'h01; // [R2]
        vStartDone <= (vCnt_q >= {1'b0, verticalStartOffset, 1'b0}); // [R1]
      end else if (dotClkTick && !hStartDone) begin
        hCnt_q <= hCnt_q + 7'h01; // [R6]
        hStartDone <= (hCnt_q >= {horizCfg.horizontalStartOffset, 1'b0}); // [R5]
      end
    end
  end

  function automatic logic [1:0] dotPeriods(input logic [1:0] f);
    case (f)
      2'h1: dotPeriods = 2'h2; // [R4]
      2'h2: dotPeriods = 2'h3;
      default: dotPeriods = 2'h1;
    endcase
  endfunction
  wire [1:0] curPeriods = dotPeriods(lineSel ? horizCfg.widthLine2 : horizCfg.widthLine1); // [R25]
  logic [1:0] dotCnt_q;
  logic dotLatch_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dotCnt_q <= 2'h0;
      dotLatch_q <= 1'h0;
      pixelOut <= 1'h0;
    end else if (clkEn) begin
      if (dotClkTick) begin
        if (dotCnt_q + 2'h1 >= curPeriods) begin
          dotCnt_q <= 2'h0;
          dotLatch_q <= charPixel; // [R4]
        end else begin
          dotCnt_q <= dotCnt_q + 2'h1;
        end
      end
      if (!dispCfg.characterDisplayEnable || !hStartDone || !vStartDone) pixelOut <= 1'h0; // [R24]
      else if (dispCfg.blinkEnable && blinkPhase_q)
        pixelOut <= dispCfg.reverseVideoEnable ? !dotLatch_q : 1'h0; // [R16]
      else pixelOut <= dotLatch_q;
    end
  end

  // ****************************************
  // video format outputs
  // ****************************************
  logic [1:0] sepSync_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chromaEnable <= 1'h0;
      burstEnable <= 1'h0;
      separatorOut <= 1'h0;
      sepSync_q <= 2'h0;
    end else if (clkEn) begin
      chromaEnable <= !(videoCfg.halfLevelMode || videoCfg.backgroundColorOff); // [R18]
      burstEnable <= !videoCfg.burstDisable; // [R19]
      sepSync_q <= {sepSync_q[0], sepSignal};
      separatorOut <= separatorOutputSelect ? 1'h1 : sepSync_q[1]; // [R21]
    end
  end
endmodule // osdc_cmd

// ==== src/osdc_map.svh ====
// command codes, reset values and timing counts for the osd command block
`ifndef OSDC_MAP_SVH
`define OSDC_MAP_SVH
`define OSDC_OP_ADDR 4'h8
`define OSDC_OP_CHAR 4'h9
`define OSDC_OP_VERT 4'ha
`define OSDC_OP_HORIZ 4'hb
`define OSDC_OP_PRIM 4'hc
`define OSDC_OP_VIDEO 4'hd
`define OSDC_OP_SYNC 4'he
`define OSDC_RST_BYTE 8'h00
`define OSDC_ERASE_CODE 7'h7f
`define OSDC_ERASE_US 500
`define OSDC_CLK_MHZ 50
`define OSDC_ERASE_CYC (`OSDC_ERASE_US * `OSDC_CLK_MHZ)
`define OSDC_BLINK_FAST_MS 500
`define OSDC_BLINK_SLOW_MS 1000
`define OSDC_BLINK_FAST_CYC (`OSDC_BLINK_FAST_MS * 1000 * `OSDC_CLK_MHZ / 2)
`define OSDC_BLINK_SLOW_CYC (`OSDC_BLINK_SLOW_MS * 1000 * `OSDC_CLK_MHZ / 2)
`define OSDC_VRAM_DEPTH 288
`endif

// ==== src/osdc_pkg.sv ====
// types shared by the osd command block
package osdc_pkg;
  typedef struct packed {
    logic [1:0] widthLine2;
    logic [1:0] widthLine1;
    logic [5:0] horizontalStartOffset;
  } osdc_horiz_t;
  typedef struct packed {
    logic fillAreaSelect;
    logic blankingSizeSelect;
    logic blankingAuxSelect;
    logic blinkPeriodSelect;
    logic blinkEnable;
    logic reverseVideoEnable;
    logic characterDisplayEnable;
  } osdc_disp_t;
  typedef struct packed {
    logic tvStandardSelect;
    logic lineCountSelect;
    logic progressiveScanSelect;
    logic internalSync;
    logic halfLevelMode;
    logic backgroundColorOff;
    logic burstDisable;
    logic [2:0] backgroundHue;
  } osdc_video_t;
  typedef enum logic [2:0] {
    HUE_CYAN, HUE_YELLOW, HUE_RED, HUE_BLUE, HUE_CYAN_BLUE, HUE_GREEN, HUE_ORANGE, HUE_MAGENTA
  } osdc_hue_t;
endpackage

// ==== testbench/osdc_cmd_monitor.sv ====
// assertion checker for the osd command block
`timescale 1ns/10ps
module osdc_cmd_monitor import osdc_pkg::*; #(
  parameter int ERASE_CYC = 300
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // inputs
  input wire logic serialChipSelect_n,
  input wire logic sepSignal,
  // outputs
  input wire osdc_horiz_t horizCfg,
  input wire osdc_disp_t dispCfg,
  input wire osdc_video_t videoCfg,
  input wire logic separatorOutputSelect,
  input wire logic oscillatorHalt,
  input wire logic eraseBusy,
  input wire logic pixelOut,
  input wire logic hStartDone,
  input wire logic vStartDone,
  input wire logic chromaEnable,
  input wire logic burstEnable,
  input wire logic separatorOut
);
  localparam int ERASE_MIN = ERASE_CYC - 16;
  localparam int ERASE_MAX = ERASE_CYC + 4;
  logic [15:0] busyLen_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busyLen_q <= 16'h0;
    end else begin
      busyLen_q <= eraseBusy ? busyLen_q + 16'h1 : 16'h0;
    end
  end
  sequence eraseStart;
    $rose(eraseBusy);
  endsequence
  sequence videoSettled;
    $stable(videoCfg) [*4];
  endsequence
  reset_clear_a: assert property ($rose(arst_n) |-> !(|{horizCfg, dispCfg, videoCfg}))
    else $error("config not clear after reset");
  erase_span_a: assert property ($fell(eraseBusy) |-> busyLen_q >= ERASE_MIN && busyLen_q <= ERASE_MAX)
    else $error("erase busy length wrong");
  erase_end_a: assert property (eraseStart |-> ##[1:ERASE_MAX] !eraseBusy)
    else $error("erase never ends");
  burst_map_a: assert property (videoSettled |-> burstEnable == !videoCfg.burstDisable)
    else $error("burst enable wrong");
  chroma_map_a: assert property (videoSettled |->
    chromaEnable == !(videoCfg.halfLevelMode || videoCfg.backgroundColorOff))
    else $error("chroma enable wrong");
  display_off_a: assert property (!dispCfg.characterDisplayEnable [*3] |-> !pixelOut)
    else $error("pixel shown while display off");
  pixel_gate_a: assert property (!(hStartDone && vStartDone) |=> !pixelOut)
    else $error("pixel shown before start position");
  osc_release_a: assert property (
    (videoCfg.internalSync || dispCfg.characterDisplayEnable) [*2] |-> !oscillatorHalt)
    else $error("oscillator halted out of mode");
  sep_route_a: assert property ((!separatorOutputSelect && $stable(sepSignal)) [*4] |->
    separatorOut == sepSignal)
    else $error("separator output not routed");
  cfg_idle_a: assert property (serialChipSelect_n [*8] |->
    $stable(horizCfg) && $stable(dispCfg) && $stable(videoCfg))
    else $error("config changed while deselected");
endmodule // osdc_cmd_monitor

// ==== testbench/osdc_host_model.sv ====
// behavioural host driving the serial command pins
`timescale 1ns/10ps
module osdc_host_model (
  // serial command pins
  output logic serialChipSelect_n,
  output logic serialClk,
  output logic serialData
);
  initial begin
    serialChipSelect_n = 1'b1;
    serialClk = 1'b0;
    serialData = 1'b0;
  end
  task automatic frameStart();
    serialChipSelect_n = 1'b0;
    #400;
  endtask
  // lsb first; clock stands low between bytes and frames
  task automatic sendByte(input logic [7:0] b, input int half);
    for (int i = 0; i < 8; i++) begin
      serialData = b[i];
      #(half) serialClk = 1'b1;
      #(half) serialClk = 1'b0;
    end
  endtask
  // released data line shows the inverse, not a stale bit
  task automatic frameEnd();
    #400 serialData = ~serialData;
    serialChipSelect_n = 1'b1;
    #1000;
  endtask
endmodule // osdc_host_model

// ==== testbench/tb_osdc_cmd.sv ====
// self-checking testbench for the osd command block
`timescale 1ns/10ps
module tb_osdc_cmd;
  typedef struct {int kind; logic [9:0] exp;} osdc_note_t;
  logic mclk, arst_n, hsyncPulse, dotClkTick, charPixel, lineSel, sepSignal;
  logic [6:0] vramRdAddr, vramRdData;
  logic [5:0] verticalStartOffset;
  logic serialChipSelect_n, serialClk, serialData, separatorOutputSelect, factoryTestSelect;
  logic oscillatorHalt, eraseBusy, pixelOut, chromaEnable, burstEnable, hStartDone;
  logic vStartDone, separatorOut;
  osdc_pkg::osdc_horiz_t horizCfg;
  osdc_pkg::osdc_disp_t dispCfg;
  osdc_pkg::osdc_video_t videoCfg;
  osdc_note_t notes[$];
  int errCount, checked, halfNs;
  event noteReady;
  osdc_cmd #(.ERASE_CYC(300), .BLINK_FAST_CYC(8), .BLINK_SLOW_CYC(16)) osdc_cmd_i (
    .mclk(mclk), .arst_n(arst_n), .clkEn(1'b1), .serialChipSelect_n(serialChipSelect_n),
    .serialClk(serialClk), .serialData(serialData), .hsyncPulse(hsyncPulse),
    .dotClkTick(dotClkTick), .charPixel(charPixel), .lineSel(lineSel), .sepSignal(sepSignal),
    .vramRdAddr(vramRdAddr), .horizCfg(horizCfg), .dispCfg(dispCfg), .videoCfg(videoCfg),
    .verticalStartOffset(verticalStartOffset), .separatorOutputSelect(separatorOutputSelect),
    .factoryTestSelect(factoryTestSelect), .oscillatorHalt(oscillatorHalt),
    .eraseBusy(eraseBusy), .pixelOut(pixelOut), .chromaEnable(chromaEnable),
    .burstEnable(burstEnable), .hStartDone(hStartDone), .vStartDone(vStartDone),
    .separatorOut(separatorOut), .vramRdData(vramRdData));
  osdc_host_model host_i (.serialChipSelect_n(serialChipSelect_n), .serialClk(serialClk),
    .serialData(serialData));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    logic [31:0] rnd;
    rnd = $urandom;
    {hsyncPulse, dotClkTick, charPixel, lineSel} <= rnd[3:0];
    sepSignal <= (sepSignal === 1'b1) ^ (rnd[9:4] == 6'h0);
  end
  // ************
  // checking
  // ************
  task automatic note(input int kind, input logic [9:0] exp);
    osdc_note_t n;
    n.kind = kind;
    n.exp = exp;
    notes.push_back(n);
  endtask
  task automatic compare(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic testDone();
    $display("counts: %0d compared, %0d mismatched", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    osdc_note_t n;
    logic [9:0] got;
    forever begin
      @(noteReady);
      @(negedge mclk);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.kind)
          0: got = horizCfg;
          1: got = {3'h0, dispCfg};
          2: got = videoCfg;
          3: got = {4'h0, verticalStartOffset};
          4: got = {3'h0, vramRdData};
          default: got = {7'h0, factoryTestSelect, oscillatorHalt, separatorOutputSelect};
        endcase
        compare(got, n.exp);
      end
    end
  end
  // ************
  // stimulus
  // ************
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n);
    host_i.frameStart();
    host_i.sendByte(a, halfNs);
    if (n > 1) host_i.sendByte(b & 8'h7f, halfNs);
    if (n > 2) host_i.sendByte(c & 8'h7f, halfNs);
    host_i.frameEnd();
    ->noteReady;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    #400000;
    errCount++;
    testDone();
  end
  initial begin
    logic [7:0] d;
    logic [3:0] k;
    arst_n = 1'b0;
    vramRdAddr = 7'h0;
    halfNs = 80;
    void'($urandom(35));
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 5; i++) note(i == 4 ? 5 : i, 10'h0);
    ->noteReady;
    repeat (4) @(negedge mclk);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      k = 4'(i * 5);
      d = 8'($urandom);
      note(0, {k, d[5:0]});
      frame({4'hb, k}, 8'($urandom), d, 3);
    end
    d = 8'($urandom);
    note(3, {4'h0, d[5:0]});
    frame(8'ha0, d, 8'h0, 2);
    $display("test position done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & (i == 3 ? 8'h7e : 8'h7f);
      note(1, {3'h0, d[6:0]});
      frame(8'hc0, d, 8'h0, 2);
    end
    note(1, 10'h0);
    frame(8'hc4, 8'h00, 8'h0, 2);
    for (int t = 0; t < 400 && eraseBusy !== 1'b0; t++) @(negedge mclk);
    vramRdAddr = 7'($urandom);
    repeat (2) @(negedge mclk);
    note(4, 10'h07f);
    ->noteReady;
    repeat (3) @(negedge mclk);
    $display("test control done");
    for (int i = 0; i < 8; i++) begin
      k = 4'($urandom);
      d = {2'b0, 3'($urandom), 3'(i)};
      note(2, {k, d[5:0]});
      frame({4'hd, k}, d, 8'h0, 2);
    end
    note(2, 10'h0);
    frame(8'hd0, 8'h00, 8'h0, 2);
    note(5, 10'h2);
    frame(8'hc2, 8'h00, 8'h0, 2);
    note(1, 10'h1);
    note(5, 10'h0);
    frame(8'hc2, 8'h01, 8'h0, 2);
    halfNs = 200;
    note(5, 10'h1);
    frame(8'he8, 8'h00, 8'h0, 2);
    note(5, 10'h0);
    frame(8'he0, 8'h00, 8'h0, 2);
    repeat (200) @(negedge mclk);
    $display("test video done");
    halfNs = 80;
    note(0, {4'h5, 6'h0a});
    frame(8'hb5, 8'h0a, 8'h0, 2);
    for (int i = 0; i < 4; i++) note(i, 10'h0);
    frame(8'hc1, 8'h00, 8'h0, 1);
    repeat (10) @(negedge mclk);
    $display("test soft reset done");
    note(0, {4'h5, 6'h0a});
    frame(8'hb5, 8'h0a, 8'h0, 2);
    repeat (4) @(negedge mclk);
    arst_n = 1'b0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    note(0, 10'h0);
    ->noteReady;
    repeat (4) @(negedge mclk);
    $display("test mid reset done");
    testDone();
  end
endmodule // tb_osdc_cmd
bind osdc_cmd osdc_cmd_monitor #(.ERASE_CYC(ERASE_CYC)) osdc_cmd_monitor_i (
  .mclk(mclk), .arst_n(arst_n), .serialChipSelect_n(serialChipSelect_n),
  .sepSignal(sepSignal), .horizCfg(horizCfg), .dispCfg(dispCfg), .videoCfg(videoCfg),
  .separatorOutputSelect(separatorOutputSelect), .oscillatorHalt(oscillatorHalt),
  .eraseBusy(eraseBusy), .pixelOut(pixelOut), .hStartDone(hStartDone),
  .vStartDone(vStartDone), .chromaEnable(chromaEnable),
  .burstEnable(burstEnable), .separatorOut(separatorOut));
